// *** core/prescaled_interval_timer.v ***
// What this block does
// - Sixteen-bit count decrements once per prescaler group
// - Eight-bit scale register sets group length
// - Interrupt flag set on the tick that finds the count at zero
// - Zero reloads count from period register
`timescale 1ns/1ps
`default_nettype none
`include "interval_timer_defines.vh"

module prescaled_interval_timer #(
    parameter COUNT_W = 16,
    parameter SCALE_W = 8,
    parameter ADDR_W  = 4,
    parameter DATA_W  = 16
) (
    // Clock, reset, enable
    input  wire              ref_clk,
    input  wire              rst,
    input  wire              clkEn,
    // Register port
    input  wire [ADDR_W-1:0] regAddr,
    input  wire [DATA_W-1:0] regWrData,
    input  wire              regWr,
    input  wire              regRd,
    output reg  [DATA_W-1:0] regRdData,
    // Interrupt
    output wire              timerIrq
);

    reg  [SCALE_W-1:0] prescale_q;
    reg  [COUNT_W-1:0] period_q;
    reg                enable_q;
    reg                irqStatus_q;
    reg                irqMask_q;
    wire [COUNT_W-1:0] count;
    wire               tick;
    wire               zeroEvent;
    wire               countLoad;
    wire               scaleWrite;
    wire [SCALE_W-1:0] groupLength;

    // Address match used by both write and read decoding
    function hit;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-1:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    assign countLoad  = regWr && hit(regAddr, `TMR_ADDR_DOWN_COUNT);
    assign scaleWrite = regWr && hit(regAddr, `TMR_ADDR_PRESCALE);

    // The register updates at the same edge as the restart, so forward the new value
    assign groupLength = scaleWrite ? regWrData[SCALE_W-1:0] : prescale_q;

    // Prescaler restarts on a scale write so the new length applies at once
    timer_prescaler #(
        .SCALE_W (SCALE_W)
    ) timer_prescaler_inst (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .clkEn      (clkEn),
        .run        (enable_q),
        .restart    (scaleWrite),
        .scaleValue (groupLength),
        .tick       (tick)
    );

    timer_down_counter #(
        .COUNT_W (COUNT_W)
    ) timer_down_counter_inst (
        .ref_clk     (ref_clk),
        .rst         (rst),
        .clkEn       (clkEn),
        .tick        (tick),
        .load        (countLoad),
        .loadValue   (regWrData[COUNT_W-1:0]),
        .periodValue (period_q),
        .count_q     (count),
        .zeroEvent   (zeroEvent)
    );

    // Software-written configuration
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            prescale_q <= `TMR_RST_PRESCALE;
            period_q   <= `TMR_RST_RELOAD_PERIOD;
            enable_q   <= `TMR_RST_CONTROL;
            irqMask_q  <= `TMR_RST_IRQ_MASK;
        end
        else if (clkEn && regWr)
        begin
            if (hit(regAddr, `TMR_ADDR_PRESCALE))
                prescale_q <= regWrData[SCALE_W-1:0];
            if (hit(regAddr, `TMR_ADDR_RELOAD_PERIOD))
                period_q <= regWrData[COUNT_W-1:0];
            if (hit(regAddr, `TMR_ADDR_CONTROL))
                enable_q <= regWrData[`TMR_CTRL_ENABLE_BIT];
            if (hit(regAddr, `TMR_ADDR_IRQ_MASK))
                irqMask_q <= regWrData[`TMR_IRQ_ZERO_BIT];
        end
    end

    // Sticky zero flag; a new event wins over a write-one clear
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            irqStatus_q <= 1'b0;
        else if (clkEn)
        begin
            if (zeroEvent)
                irqStatus_q <= 1'b1;
            else if (regWr && hit(regAddr, `TMR_ADDR_IRQ_STATUS)
                     && regWrData[`TMR_IRQ_ZERO_BIT])
                irqStatus_q <= 1'b0;
        end
    end

    assign timerIrq = irqStatus_q && irqMask_q;

    // Read data valid the cycle after the strobe, zero otherwise
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            regRdData <= {DATA_W{1'b0}};
        else if (clkEn)
        begin
            regRdData <= {DATA_W{1'b0}};
            if (regRd)
            begin
                if (hit(regAddr, `TMR_ADDR_DOWN_COUNT))
                    regRdData <= {{(DATA_W-COUNT_W){1'b0}}, count};
                else if (hit(regAddr, `TMR_ADDR_PRESCALE))
                    regRdData <= {{(DATA_W-SCALE_W){1'b0}}, prescale_q};
                else if (hit(regAddr, `TMR_ADDR_RELOAD_PERIOD))
                    regRdData <= {{(DATA_W-COUNT_W){1'b0}}, period_q};
                else if (hit(regAddr, `TMR_ADDR_CONTROL))
                    regRdData <= {{(DATA_W-1){1'b0}}, enable_q};
                else if (hit(regAddr, `TMR_ADDR_IRQ_STATUS))
                    regRdData <= {{(DATA_W-1){1'b0}}, irqStatus_q};
                else if (hit(regAddr, `TMR_ADDR_IRQ_MASK))
                    regRdData <= {{(DATA_W-1){1'b0}}, irqMask_q};
            end
        end
    end

endmodule // prescaled_interval_timer

`default_nettype wire

// *** core/interval_timer_defines.vh ***
`ifndef INTERVAL_TIMER_DEFINES_VH
`define INTERVAL_TIMER_DEFINES_VH

// Register word addresses on the plain register port
`define TMR_ADDR_DOWN_COUNT    4'h0
`define TMR_ADDR_PRESCALE      4'h1
`define TMR_ADDR_RELOAD_PERIOD 4'h2
`define TMR_ADDR_CONTROL       4'h3
`define TMR_ADDR_IRQ_STATUS    4'h4
`define TMR_ADDR_IRQ_MASK      4'h5

// Control register fields
`define TMR_CTRL_ENABLE_BIT    0

// Interrupt status and mask fields
`define TMR_IRQ_ZERO_BIT       0

// Reset values
`define TMR_RST_DOWN_COUNT     16'h0000
`define TMR_RST_PRESCALE       8'h00
`define TMR_RST_RELOAD_PERIOD  16'h0000
`define TMR_RST_CONTROL        1'b0
`define TMR_RST_IRQ_MASK       1'b0

`endif

// *** core/timer_prescaler.v ***
`timescale 1ns/1ps
`default_nettype none

module timer_prescaler #(
    parameter SCALE_W = 8
) (
    // Clock and reset
    input  wire               ref_clk,
    input  wire               rst,
    input  wire               clkEn,
    // Control
    input  wire               run,
    input  wire               restart,
    input  wire [SCALE_W-1:0] scaleValue,
    // Output
    output wire               tick
);

    reg [SCALE_W-1:0] groupCnt_q;

    // One tick every scaleValue plus one cycles
    assign tick = run && (groupCnt_q == {SCALE_W{1'b0}});

    // Counts down through the group; restart realigns after a write
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            groupCnt_q <= {SCALE_W{1'b0}};
        else if (clkEn)
        begin
            if (restart || !run)
                groupCnt_q <= scaleValue;
            else if (tick)
                groupCnt_q <= scaleValue;
            else
                groupCnt_q <= groupCnt_q - {{(SCALE_W-1){1'b0}}, 1'b1};
        end
    end

endmodule // timer_prescaler

`default_nettype wire

// *** core/timer_down_counter.v ***
`timescale 1ns/1ps
`default_nettype none

module timer_down_counter #(
    parameter COUNT_W = 16
) (
    // Clock and reset
    input  wire               ref_clk,
    input  wire               rst,
    input  wire               clkEn,
    // Control
    input  wire               tick,
    input  wire               load,
    input  wire [COUNT_W-1:0] loadValue,
    input  wire [COUNT_W-1:0] periodValue,
    // State
    output reg  [COUNT_W-1:0] count_q,
    output wire               zeroEvent
);

    // The reload happens on the tick that finds zero
    assign zeroEvent = tick && (count_q == {COUNT_W{1'b0}});

    // Software load beats a tick in the same cycle so writes are never lost
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            count_q <= {COUNT_W{1'b0}};
        else if (clkEn)
        begin
            if (load)
                count_q <= loadValue;
            else if (zeroEvent)
                count_q <= periodValue;
            else if (tick)
                count_q <= count_q - {{(COUNT_W-1){1'b0}}, 1'b1};
        end
    end

endmodule // timer_down_counter

`default_nettype wire

// *** tb/timer_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module timer_props (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        clkEn,
    // Register port
    input wire logic [3:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [15:0] regRdData,
    // Interrupt
    input wire logic        timerIrq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Request is sticky, only a write can drop it
    irq_sticky_a: assert property (timerIrq && !regWr |=> timerIrq)
        else $error("irq dropped");
    scale_back_a: assert property (regWr && clkEn && regAddr == 4'h1 ##1 regRd && clkEn
        && regAddr == 4'h1 |=> regRdData == {8'h00, $past(regWrData[7:0], 2)})
        else $error("scale readback");
    period_back_a: assert property (regWr && clkEn && regAddr == 4'h2 ##1 regRd && clkEn
        && regAddr == 4'h2 |=> regRdData == $past(regWrData, 2))
        else $error("period readback");
    // One cycle apart the count moves by one step at most unless it reloads from zero
    count_step_a: assert property (regRd && clkEn && regAddr == 4'h0 ##1 regRd
        && clkEn && regAddr == 4'h0 |=> regRdData == $past(regRdData)
        || regRdData == $past(regRdData) - 16'h0001 || $past(regRdData) == 16'h0000)
        else $error("count step");
    rd_idle_a: assert property (!regRd && clkEn |=> regRdData == 16'h0000)
        else $error("idle read data");
endmodule // timer_props
bind prescaled_interval_timer timer_props timer_props_inst (.ref_clk(ref_clk), .rst(rst),
    .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .timerIrq(timerIrq));
`default_nettype wire

// *** tb/prescaled_interval_timer_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module prescaled_interval_timer_tb;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        clkEn = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    wire  [15:0] regRdData;
    wire         timerIrq;
    int          nFail = 0;
    int          nCompared = 0;
    int          cyc = 0;
    int          n;
    // Clock at 50 MHz
    always #10 ref_clk = ~ref_clk;
    prescaled_interval_timer prescaled_interval_timer_inst (.ref_clk(ref_clk), .rst(rst),
        .clkEn(clkEn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .timerIrq(timerIrq));
    task automatic give_verdict;
        $display("compared %0d failed %0d", nCompared, nFail);
        if (nFail == 0 && nCompared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        nCompared++;
        if (g !== e)
        begin
            nFail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Callers enter right after a rising edge; the write strobe is lowered by the next caller
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        regWr <= 1'b0;
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(posedge ref_clk);
        chk("read", e, regRdData);
    endtask
    // Values seen at an edge are those standing before it
    task automatic waitIrq(output int c);
        c = 0;
        regWr <= 1'b0;
        do
        begin
            @(posedge ref_clk);
            c++;
        end while (timerIrq !== 1'b1 && c < 500);
    endtask
    // Hang guard
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            nFail++;
            give_verdict;
        end
    end
    initial
    begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++)
            rd(a[3:0], 16'h0000);
        wr(4'h7, 16'hFFFF);
        rd(4'h7, 16'h0000);
        wr(4'h1, 16'hABCD);
        rd(4'h1, 16'h00CD);
        wr(4'h2, 16'h1234);
        rd(4'h2, 16'h1234);
        wr(4'h0, 16'h5A5A);
        rd(4'h0, 16'h5A5A);
        wr(4'h5, 16'h0001);
        for (int s = 0; s < 3; s += 2)
        begin
            wr(4'h1, s[15:0]);
            wr(4'h2, 16'h0003 + s[15:0]);
            wr(4'h0, 16'h0000);
            wr(4'h3, 16'h0001);
            waitIrq(n);
            wr(4'h4, 16'h0001);
            waitIrq(n);
            chk("interval", 16'((4 + s) * (s + 1)), 16'(n + 1));
            wr(4'h3, 16'h0000);
            wr(4'h4, 16'h0001);
        end
        // Masked run while reading the count back to back
        wr(4'h5, 16'h0000);
        wr(4'h3, 16'h0001);
        regWr <= 1'b0;
        regRd <= 1'b1;
        regAddr <= 4'h0;
        repeat (40) @(posedge ref_clk);
        // The read strobe stays up into the next read, so it is not lowered here
        chk("masked irq", 16'h0000, {15'h0000, timerIrq});
        rd(4'h4, 16'h0001);
        wr(4'h5, 16'h0001);
        rd(4'h5, 16'h0001);
        chk("irq", 16'h0001, {15'h0000, timerIrq});
        give_verdict;
    end
endmodule // prescaled_interval_timer_tb
`default_nettype wire
